// ==== bench/p3wk_wake_compare_tb_top.sv ====
// Self-checking bench for the port 3 wake compare block
`timescale 1ns/1ps
module p3wk_wake_compare_tb_top
    import p3wk_pkg::*;
;
    logic clk = 0, reset_n = 0;
    logic [11:0] regAddr = '0;
    logic [7:0] regWdata = '0, regRdata;
    logic regWrite = 0, regRead = 0, port3Read = 0, port3Write = 0;
    logic [3:0] port3Value = '0, port3Pins = 4'hF;
    logic port2Read = 0, port2Write = 0, port2Selected = 0;
    logic port3ModeIrqBit = 0, otherWakeSources = 0;
    logic wakeFromHalt, interruptLineOne;
    int nFail = 0, numChecks = 0;
    always #5 clk = ~clk;
    p3wk_wake_compare u_dut (.clk(clk), .reset_n(reset_n),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata), .port3Read(port3Read),
        .port3Write(port3Write), .port3Value(port3Value),
        .port2Read(port2Read), .port2Write(port2Write),
        .port2Selected(port2Selected), .port3Pins(port3Pins),
        .port3ModeIrqBit(port3ModeIrqBit),
        .otherWakeSources(otherWakeSources),
        .wakeFromHalt(wakeFromHalt), .interruptLineOne(interruptLineOne));
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        numChecks++;
        if (g !== e) begin
            nFail++;
            $display("Error %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk) {regAddr, regWdata, regWrite} <= {a, d, 1'b1};
        @(posedge clk) regWrite <= 0;
    endtask
    task rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk) {regAddr, regRead} <= {a, 1'b1};
        @(posedge clk) regRead <= 0;
        #1 chk("regRdata", e, regRdata);
    endtask
    // Port 3 data register access, write when w is 1
    task acc(input logic w, input logic [3:0] v);
        @(posedge clk) {port3Write, port3Read, port3Value} <= {w, !w, v};
        @(posedge clk) {port3Write, port3Read} <= 2'b00;
    endtask
    // Two flops of latency; a third edge keeps the sample clear of it
    task pins(input logic [3:0] v, input logic e);
        @(posedge clk) port3Pins <= v;
        repeat (3) @(posedge clk);
        #1 chk("wakeFromHalt", {7'h00, e}, {7'h00, wakeFromHalt});
    endtask
    task t_reset;
        rd(ADDR_WAKE_STATUS_CONTROL, 8'h00);
        rd(ADDR_PORT3_WAKE_SELECT, 8'h00);
        rd(12'h123, 8'h00);
        wr(12'h123, 8'h1F);
        rd(ADDR_WAKE_STATUS_CONTROL, 8'h00);
    endtask
    task t_default;
        wr(ADDR_PORT3_WAKE_SELECT, 8'hF1);
        pins(4'hF, 0);
        pins(4'hE, 1);
        pins(4'hD, 0);
    endtask
    task t_write_ref;
        acc(1, 4'h0);
        rd(ADDR_WAKE_STATUS_CONTROL, 8'h08);
        pins(4'hF, 1);
        pins(4'hE, 0);
    endtask
    task t_read_ref;
        acc(0, 4'h1);
        rd(ADDR_WAKE_STATUS_CONTROL, 8'h04);
        pins(4'hF, 0);
        pins(4'hE, 1);
    endtask
    task t_multi;
        wr(ADDR_PORT3_WAKE_SELECT, 8'hFF);
        acc(1, 4'h5);
        pins(4'h5, 0);
        pins(4'h4, 1);
        pins(4'h7, 1);
    endtask
    task t_clear;
        wr(ADDR_WAKE_STATUS_CONTROL, 8'h00);
        rd(ADDR_WAKE_STATUS_CONTROL, 8'h00);
        pins(4'hF, 0);
        pins(4'h7, 1);
    endtask
    task t_irq;
        wr(ADDR_WAKE_STATUS_CONTROL, 8'h10);
        rd(ADDR_WAKE_STATUS_CONTROL, 8'h10);
        chk("interruptLineOne", 8'h01, {7'h00, interruptLineOne});
        wr(ADDR_WAKE_STATUS_CONTROL, 8'h00);
        @(posedge clk) #1;
        chk("interruptLineOne", 8'h00, {7'h00, interruptLineOne});
        @(posedge clk) port3ModeIrqBit <= 1;
        repeat (2) @(posedge clk);
        #1 chk("interruptLineOne", 8'h01, {7'h00, interruptLineOne});
        @(posedge clk) port3ModeIrqBit <= 0;
        pins(4'hF, 0);
        @(posedge clk) otherWakeSources <= 1;
        repeat (3) @(posedge clk);
        #1 chk("wakeFromHalt", 8'h01, {7'h00, wakeFromHalt});
        @(posedge clk) otherWakeSources <= 0;
    endtask
    task t_port2;
        @(posedge clk) {port2Selected, port2Write} <= 2'b11;
        @(posedge clk) port2Write <= 0;
        rd(ADDR_WAKE_STATUS_CONTROL, 8'h02);
        @(posedge clk) port2Read <= 1;
        @(posedge clk) port2Read <= 0;
        rd(ADDR_WAKE_STATUS_CONTROL, 8'h01);
        @(posedge clk) {port2Selected, port2Write} <= 2'b01;
        @(posedge clk) port2Write <= 0;
        rd(ADDR_WAKE_STATUS_CONTROL, 8'h01);
    endtask
    task testDone;
        if (nFail == 0 && numChecks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1;
        t_reset();
        t_default();
        t_write_ref();
        t_read_ref();
        t_multi();
        t_clear();
        t_irq();
        t_port2();
        testDone();
    end
    // The whole sequence takes well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        nFail++;
        testDone();
    end
endmodule

// ==== inc/p3wk_pkg.sv ====
// Constants and types shared by the port 3 wake compare block
package p3wk_pkg;
    // Register offsets (linear addresses)
    localparam logic [11:0] ADDR_WAKE_STATUS_CONTROL = 12'hF0A;
    localparam logic [11:0] ADDR_PORT3_WAKE_SELECT = 12'hF0E;
    // Field positions
    localparam int SEL_LSB = 0;
    localparam int SEL_W = 4;
    localparam int P2_ORIGIN_LSB = 0;
    localparam int P3_ORIGIN_LSB = 2;
    localparam int IRQ_EN_BIT = 4;
    localparam int P3M_IRQ_BIT = 1;
    // Reset values
    localparam logic [3:0] SEL_RESET = 4'h0;
    localparam logic [7:0] WSC_RESET = 8'h00;
    // Reference origin codes
    typedef enum logic [1:0] {
        ORIGIN_NONE = 2'h0,
        ORIGIN_READ = 2'h1,
        ORIGIN_WRITE = 2'h2,
        ORIGIN_RSVD = 2'h3
    } p3wk_origin_t;
endpackage

// ==== logic/p3wk_pin_cmp.sv ====
// One port 3 pin compare cell: reference bit and mismatch flag
`timescale 1ns/1ps
module p3wk_pin_cmp
    import p3wk_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Control
    input wire logic selected,
    input wire logic capture,
    input wire logic captureValue,
    input wire logic useRef,
    // Pin and result
    input wire logic pinLevel,
    output logic mismatch
);
    typedef struct packed {
        logic refBit;
        logic mismatch;
    } p3wk_cell_t;

    p3wk_cell_t state;
    p3wk_cell_t next_state;

    always_comb begin
        next_state = state;
        if (capture) begin
            next_state.refBit = captureValue;
        end
        // Default compares with zero; with a reference, any difference
        next_state.mismatch = selected &&
            (useRef ? (pinLevel != state.refBit) : !pinLevel);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign mismatch = state.mismatch;

    a_unsel_quiet: assert property (
        @(posedge clk) disable iff (!reset_n)
        !$past(selected) |-> !mismatch)
        else $error("unselected pin flagged a mismatch");
endmodule

// ==== logic/p3wk_wake_compare.sv ====
// Port 3 wake compare logic with its two control registers
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - A 1 in bits 3:0 of port3_wake_select enables that port 3 pin.
// - Any set of the four pins may be selected, each compared alone.
// - Without a reference, a selected pin wakes when it reads zero.
// - Once selected, each port 3 data read or write captures the ref.
// - With a reference, a selected pin wakes when it differs from it.
// - Status bits 3:2 show port 3 origin: 00 none, 01 read, 10 write.
// - Software may clear bits 3:2 to 00 to return to zero compare.
// - Status bits 1:0 show port 2 origin: 00 none, 01 read, 10 write.
// - Bit 4 routes wake events to interrupt line one.
// - Neither register is reinitialised by wake recovery.
// - Any one enabled wake source is enough to trigger recovery.
module p3wk_wake_compare
    import p3wk_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [11:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    // Port data register accesses
    input wire logic port3Read,
    input wire logic port3Write,
    input wire logic [3:0] port3Value,
    input wire logic port2Read,
    input wire logic port2Write,
    input wire logic port2Selected,
    // Pins and mode
    input wire logic [3:0] port3Pins,
    input wire logic port3ModeIrqBit,
    input wire logic otherWakeSources,
    // Results
    output logic wakeFromHalt,
    output logic interruptLineOne
);
    typedef struct packed {
        logic [3:0] select;
        logic irqEnable;
        p3wk_origin_t p3Origin;
        p3wk_origin_t p2Origin;
        logic [7:0] rdata;
        logic wake;
        logic irq;
    } p3wk_state_t;

    p3wk_state_t state;
    p3wk_state_t next_state;
    logic [3:0] pinMismatch;
    logic p3Access;
    logic useRef;
    logic selWrite;
    logic statusWrite;
    logic statusRead;
    logic selRead;
    logic anyP3Access;
    logic p2Access;

    // Decoded strobes, shared by the checks below
    assign selWrite = regWrite && (regAddr == ADDR_PORT3_WAKE_SELECT);
    assign statusWrite = regWrite && (regAddr == ADDR_WAKE_STATUS_CONTROL);
    assign statusRead = regRead && (regAddr == ADDR_WAKE_STATUS_CONTROL);
    assign selRead = regRead && (regAddr == ADDR_PORT3_WAKE_SELECT);
    assign anyP3Access = port3Read || port3Write;
    assign p2Access = port2Selected && (port2Read || port2Write);

    // A capture while origin is none only arms the reference next cycle
    assign p3Access = (port3Read || port3Write) && (state.select != 4'h0);
    assign useRef = (state.p3Origin != ORIGIN_NONE);

    genvar gi;
    generate
        for (gi = 0; gi < SEL_W; gi++) begin : g_pin
            p3wk_pin_cmp u_cmp (
                .clk(clk),
                .reset_n(reset_n),
                .selected(state.select[gi]),
                .capture((port3Read || port3Write) && state.select[gi]),
                .captureValue(port3Value[gi]),
                .useRef(useRef),
                .pinLevel(port3Pins[gi]),
                .mismatch(pinMismatch[gi])
            );
        end
    endgenerate

    always_comb begin
        next_state = state;
        next_state.rdata = 8'h00;
        // Software write first; a same-cycle access then wins the field
        if (regWrite && regAddr == ADDR_PORT3_WAKE_SELECT) begin
            next_state.select = regWdata[SEL_LSB +: SEL_W];
        end
        if (regWrite && regAddr == ADDR_WAKE_STATUS_CONTROL) begin
            next_state.irqEnable = regWdata[IRQ_EN_BIT];
            next_state.p3Origin =
                p3wk_origin_t'(regWdata[P3_ORIGIN_LSB +: 2]);
            next_state.p2Origin =
                p3wk_origin_t'(regWdata[P2_ORIGIN_LSB +: 2]);
        end
        if (p3Access) begin
            next_state.p3Origin =
                port3Write ? ORIGIN_WRITE : ORIGIN_READ;
        end
        if (port2Selected && (port2Read || port2Write)) begin
            next_state.p2Origin =
                port2Write ? ORIGIN_WRITE : ORIGIN_READ;
        end
        if (regRead) begin
            unique case (regAddr)
                ADDR_WAKE_STATUS_CONTROL: begin
                    next_state.rdata = {3'h0, state.irqEnable,
                        state.p3Origin, state.p2Origin};
                end
                // Select bits are write only; all of 7:0 read as zero here
                default: begin
                    next_state.rdata = 8'h00;
                end
            endcase
        end
        next_state.wake = (|pinMismatch) ||
            otherWakeSources;
        next_state.irq = next_state.wake &&
            (state.irqEnable || port3ModeIrqBit);
    end

    // Only reset_n clears state; wake recovery has no reset path here
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= '{select: SEL_RESET, irqEnable: WSC_RESET[IRQ_EN_BIT],
                p3Origin: ORIGIN_NONE, p2Origin: ORIGIN_NONE,
                rdata: 8'h00, wake: 1'b0, irq: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign regRdata = state.rdata;
    assign wakeFromHalt = state.wake;
    assign interruptLineOne = state.irq;

    // Reference origin tracking
    a_origin_write: assert property (
        @(posedge clk) disable iff (!reset_n)
        (port3Write && state.select != 4'h0) |=>
        state.p3Origin == ORIGIN_WRITE)
        else $error("port 3 write did not mark origin write");
    a_origin_read: assert property (
        @(posedge clk) disable iff (!reset_n)
        (port3Read && !port3Write && state.select != 4'h0) |=>
        state.p3Origin == ORIGIN_READ)
        else $error("port 3 read did not mark origin read");
    a_origin_clear: assert property (
        @(posedge clk) disable iff (!reset_n)
        (regWrite && regAddr == ADDR_WAKE_STATUS_CONTROL &&
        regWdata[3:2] == 2'h0 && !p3Access) |=>
        state.p3Origin == ORIGIN_NONE)
        else $error("origin clear was not taken");
    a_p2_origin: assert property (
        @(posedge clk) disable iff (!reset_n)
        (port2Selected && port2Write) |=>
        state.p2Origin == ORIGIN_WRITE)
        else $error("port 2 write did not mark origin");
    a_p2_read: assert property (
        @(posedge clk) disable iff (!reset_n)
        (p2Access && !port2Write) |=>
        state.p2Origin == ORIGIN_READ)
        else $error("port 2 read did not mark origin");
    a_p2_keep: assert property (
        @(posedge clk) disable iff (!reset_n)
        (!p2Access && !statusWrite) |=>
        $stable(state.p2Origin))
        else $error("port 2 origin moved without a cause");
    a_p3_keep: assert property (
        @(posedge clk) disable iff (!reset_n)
        (!p3Access && !statusWrite) |=>
        $stable(state.p3Origin))
        else $error("port 3 origin moved without a cause");
    a_no_sel_origin: assert property (
        @(posedge clk) disable iff (!reset_n)
        (anyP3Access && state.select == 4'h0 && !statusWrite) |=>
        $stable(state.p3Origin))
        else $error("access with nothing selected set the origin");
    a_set_wins: assert property (
        @(posedge clk) disable iff (!reset_n)
        (p3Access && statusWrite) |=>
        state.p3Origin != ORIGIN_NONE)
        else $error("software clear beat a port 3 access");

    // Control register contents
    a_sel_write: assert property (
        @(posedge clk) disable iff (!reset_n)
        selWrite |=>
        state.select == $past(regWdata[SEL_LSB +: SEL_W]))
        else $error("select write not taken");
    a_sel_keep: assert property (
        @(posedge clk) disable iff (!reset_n)
        !selWrite |=>
        $stable(state.select))
        else $error("select changed without a write");
    a_irqen_write: assert property (
        @(posedge clk) disable iff (!reset_n)
        statusWrite |=>
        state.irqEnable == $past(regWdata[IRQ_EN_BIT]))
        else $error("interrupt enable write not taken");
    a_irqen_keep: assert property (
        @(posedge clk) disable iff (!reset_n)
        !statusWrite |=>
        $stable(state.irqEnable))
        else $error("interrupt enable changed without a write");

    // Read port
    a_read_lat: assert property (
        @(posedge clk) disable iff (!reset_n)
        (regRead && regAddr == ADDR_WAKE_STATUS_CONTROL) |=>
        regRdata[4] == $past(state.irqEnable))
        else $error("status read data wrong");
    a_status_read: assert property (
        @(posedge clk) disable iff (!reset_n)
        statusRead |=>
        regRdata[3:0] == {$past(state.p3Origin), $past(state.p2Origin)})
        else $error("status origin fields read wrong");
    a_rsvd_zero: assert property (
        @(posedge clk) disable iff (!reset_n)
        regRead |=>
        regRdata[7:5] == 3'h0)
        else $error("reserved status bits not zero");
    a_sel_read: assert property (
        @(posedge clk) disable iff (!reset_n)
        selRead |=>
        regRdata == 8'h00)
        else $error("write only select register returned data");
    a_rdata_idle: assert property (
        @(posedge clk) disable iff (!reset_n)
        !regRead |=>
        regRdata == 8'h00)
        else $error("read data stood without a read");

    // Wake and interrupt
    a_zero_wake: assert property (
        @(posedge clk) disable iff (!reset_n)
        (state.select[0] && state.p3Origin == ORIGIN_NONE &&
        !port3Pins[0]) ##1 state.select[0] |=> wakeFromHalt)
        else $error("zero level on selected pin did not wake");
    a_no_sel_quiet: assert property (
        @(posedge clk) disable iff (!reset_n)
        (state.select == 4'h0) |=>
        (pinMismatch == 4'h0))
        else $error("mismatch with no pin selected");
    a_wake_pin: assert property (
        @(posedge clk) disable iff (!reset_n)
        (|pinMismatch) |=>
        wakeFromHalt)
        else $error("pin mismatch did not wake");
    a_wake_quiet: assert property (
        @(posedge clk) disable iff (!reset_n)
        ((pinMismatch == 4'h0) && !otherWakeSources) |=>
        !wakeFromHalt)
        else $error("wake raised with no source");
    a_irq_gate: assert property (
        @(posedge clk) disable iff (!reset_n)
        interruptLineOne |-> wakeFromHalt &&
        ($past(state.irqEnable) || $past(port3ModeIrqBit)))
        else $error("interrupt without enable or wake");
    a_irq_raise: assert property (
        @(posedge clk) disable iff (!reset_n)
        (wakeFromHalt && $past(state.irqEnable)) |->
        interruptLineOne)
        else $error("enabled wake gave no interrupt");
    a_mode_irq: assert property (
        @(posedge clk) disable iff (!reset_n)
        (wakeFromHalt && $past(port3ModeIrqBit)) |->
        interruptLineOne)
        else $error("mode bit wake gave no interrupt");
    a_other_wake: assert property (
        @(posedge clk) disable iff (!reset_n)
        otherWakeSources |=> wakeFromHalt)
        else $error("other wake source ignored");
    a_wake_cause: assert property (
        @(posedge clk) disable iff (!reset_n)
        wakeFromHalt |-> $past(|pinMismatch) ||
        $past(otherWakeSources))
        else $error("wake without any cause");

    // A stuck cell would hide behind the OR, so each one is checked alone
    generate
        for (gi = 0; gi < SEL_W; gi++) begin : g_pin_chk
            a_pin_unsel: assert property (
                @(posedge clk) disable iff (!reset_n)
                !state.select[gi] |=> !pinMismatch[gi])
                else $error("unselected pin raised its mismatch");
        end
    endgenerate

    c_write_ref: cover property (@(posedge clk) disable iff (!reset_n)
        port3Write && state.select != 4'h0 ##2 wakeFromHalt);
    c_read_ref: cover property (@(posedge clk) disable iff (!reset_n)
        port3Read && state.select != 4'h0 ##1 useRef);
    c_irq: cover property (@(posedge clk) disable iff (!reset_n)
        interruptLineOne);
    c_clear: cover property (@(posedge clk) disable iff (!reset_n)
        useRef ##1 !useRef);
    c_mode_irq: cover property (@(posedge clk) disable iff (!reset_n)
        interruptLineOne && !state.irqEnable);
endmodule
